// >>> rtl/nvpe_pkg.sv
/*
  Package for the nonvolatile program and erase controller: register map,
  field positions, reset values and timing constants.
  Assumes a 100 MHz system clock and a 32-bit Avalon-MM register slave.
*/
package nvpe_pkg;
  localparam int CLK_MHZ = 100;

  // Byte addresses of the registers
  localparam logic [4:0] ADDR_FLASH_CTRL = 5'h00;
  localparam logic [4:0] ADDR_EE_PROG = 5'h04;
  localparam logic [4:0] ADDR_EE_DIVH = 5'h08;
  localparam logic [4:0] ADDR_EE_DIVL = 5'h0C;
  localparam logic [4:0] ADDR_EE_MCFG = 5'h10;
  localparam logic [4:0] ADDR_STATUS = 5'h14;

  // Flash control bits
  localparam int FC_PROG = 0;
  localparam int FC_ERASE = 1;
  localparam int FC_BUSY = 2;
  localparam int FC_ROW_LSB = 8;
  localparam int FC_ROW_W = 11;

  // EEPROM program control bits
  localparam int EP_PULSE = 0;
  localparam int EP_LATCH = 1;
  localparam int EP_ERASE = 2;
  localparam int EP_AUTO = 5;

  localparam int ROW_BYTES = 64;
  localparam int DIV_W = 10;
  localparam int DIVH_W = 2;
  localparam int DIVL_W = 8;

  // Fixed flash operation times
  localparam int FLASH_PROG_US = 20;
  localparam int FLASH_ERASE_MS = 100;
  localparam int FLASH_PROG_CYC = FLASH_PROG_US * CLK_MHZ;
  localparam int FLASH_ERASE_CYC = FLASH_ERASE_MS * 1000 * CLK_MHZ;

  // EEPROM optimum times, in time base ticks
  localparam int EE_PROG_TICKS = 10;
  localparam int EE_ERASE_TICKS = 20;
  localparam int TICK_W = 16;

  localparam logic [7:0] MCFG_RST = 8'h00;
endpackage

// >>> rtl/nvpe_tbase.sv
/*
  Time base divider for the EEPROM, counting crystal clock cycles.
  Assumes the crystal input is already synchronised to clk.
*/
`timescale 1ns/10ps
module nvpe_tbase (
  input wire logic clk,
  input wire logic rst,
  input wire logic xtal_rise,
  input wire logic [nvpe_pkg::DIV_W-1:0] prescale,
  output logic tick
);
  logic [nvpe_pkg::DIV_W-1:0] cnt_r;
  wire terminal = (cnt_r >= prescale);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      tick <= xtal_rise & terminal;
      if (xtal_rise) begin
        cnt_r <= terminal ? '0 : cnt_r + 1'b1;
      end
    end
  end
endmodule

// >>> rtl/nvpe_top.sv
/*
  Program and erase controller for on-chip flash and EEPROM, with an
  Avalon-MM register slave.
  Assumes the shadow word is stable at reset release and the crystal clock
  is slower than half of clk.
*/
// Overview of operation
// - Flash programs one whole 64-byte row per operation.
// - Flash erase clears the whole array in one bulk operation.
// - Flash erase and program are timed in hardware with fixed durations.
// - EEPROM time base comes from the crystal clock through a divider.
// - A 10-bit prescaler is split over two divider registers.
// - Divider registers are volatile and reload from the shadow word at reset.
// - Automatic timing enable sits at bit 5 of EEPROM program control.
// - Auto mode applies optimum time, then clears pulse enable; software polls.
`timescale 1ns/10ps
module nvpe_top #(
  parameter int FLASH_ERASE_CYCLES = nvpe_pkg::FLASH_ERASE_CYC,
  parameter int FLASH_PROG_CYCLES = nvpe_pkg::FLASH_PROG_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic crystal_clock_input,
  input wire logic [nvpe_pkg::DIV_W-1:0] shadow_divider,
  output logic flash_prog_active,
  output logic flash_erase_active,
  output logic [nvpe_pkg::FC_ROW_W-1:0] flash_row,
  output logic ee_hv_active,
  output logic ee_erase_mode
);
  typedef enum logic [2:0] {
    FS_IDLE = 3'b001,
    FS_PROG = 3'b010,
    FS_ERASE = 3'b100
  } nvpe_fstate_t;

  nvpe_fstate_t fstate_r, fstate_nxt;
  logic [31:0] fcnt_r;
  logic [nvpe_pkg::FC_ROW_W-1:0] row_r;
  logic shadow_load_r;
  logic [nvpe_pkg::DIVH_W-1:0] eeprom_divider_high_r;
  logic [nvpe_pkg::DIVL_W-1:0] eeprom_divider_low_r;
  logic [7:0] eeprom_module_config_r;
  logic auto_r, latch_r, ee_erase_r, program_pulse_enable_r;
  logic [nvpe_pkg::TICK_W-1:0] ticks_r;
  logic [3:0] ee_writes_r;
  logic xs1_r, xs2_r, xs3_r;
  logic ack_r;
  logic tick;

  // Bus decode
  wire req = (avs_read | avs_write) & ~ack_r;
  wire wr = avs_write & ~ack_r;
  wire sel_fc = (avs_address == nvpe_pkg::ADDR_FLASH_CTRL);
  wire sel_ep = (avs_address == nvpe_pkg::ADDR_EE_PROG);
  wire sel_dh = (avs_address == nvpe_pkg::ADDR_EE_DIVH);
  wire sel_dl = (avs_address == nvpe_pkg::ADDR_EE_DIVL);
  wire sel_mc = (avs_address == nvpe_pkg::ADDR_EE_MCFG);
  wire sel_st = (avs_address == nvpe_pkg::ADDR_STATUS);
  wire wr_fc = wr & sel_fc;
  wire wr_ep = wr & sel_ep;
  wire flash_busy = (fstate_r != FS_IDLE);
  wire start_prog = wr_fc & avs_writedata[nvpe_pkg::FC_PROG] & ~flash_busy;
  wire start_erase = wr_fc & avs_writedata[nvpe_pkg::FC_ERASE] & ~flash_busy & ~start_prog;
  wire xtal_rise = xs2_r & ~xs3_r;
  wire [nvpe_pkg::DIV_W-1:0] prescale = {eeprom_divider_high_r, eeprom_divider_low_r};
  wire [nvpe_pkg::TICK_W-1:0] ee_target = ee_erase_r ?
    nvpe_pkg::TICK_W'(nvpe_pkg::EE_ERASE_TICKS) : nvpe_pkg::TICK_W'(nvpe_pkg::EE_PROG_TICKS);
  wire ee_done = program_pulse_enable_r & auto_r & tick & (ticks_r + 1'b1 >= ee_target);
  wire [31:0] flash_limit = (fstate_r == FS_ERASE) ? 32'(FLASH_ERASE_CYCLES) : 32'(FLASH_PROG_CYCLES);
  wire flash_done = flash_busy & (fcnt_r + 1'b1 >= flash_limit);

  wire [31:0] rd_fc = {13'h0000, row_r, 5'h00, flash_busy,
                       fstate_r == FS_ERASE, fstate_r == FS_PROG};
  wire [31:0] rd_ep = {26'h0000000, auto_r, 2'h0, ee_erase_r, latch_r, program_pulse_enable_r};
  wire [31:0] rd_st = {12'h000, ticks_r, ee_writes_r};
  wire [31:0] rd_mux = sel_fc ? rd_fc :
                       sel_ep ? rd_ep :
                       sel_dh ? {30'h00000000, eeprom_divider_high_r} :
                       sel_dl ? {24'h000000, eeprom_divider_low_r} :
                       sel_mc ? {24'h000000, eeprom_module_config_r} :
                       sel_st ? rd_st : 32'h00000000;

  // Bus answer: one wait cycle, unmapped reads give zero, writes ignored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_r <= req;
      avs_waitrequest <= ~req;
      if (req) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xs1_r <= 1'b0;
      xs2_r <= 1'b0;
      xs3_r <= 1'b0;
    end else begin
      xs1_r <= crystal_clock_input;
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
    end
  end

  nvpe_tbase u_tbase (
    .clk(clk),
    .rst(rst),
    .xtal_rise(xtal_rise),
    .prescale(prescale),
    .tick(tick)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shadow_load_r <= 1'b1;
      eeprom_divider_high_r <= '0;
      eeprom_divider_low_r <= '0;
    end else begin
      shadow_load_r <= 1'b0;
      if (shadow_load_r) begin
        eeprom_divider_high_r <= shadow_divider[nvpe_pkg::DIV_W-1:nvpe_pkg::DIVL_W];
        eeprom_divider_low_r <= shadow_divider[nvpe_pkg::DIVL_W-1:0];
      end else begin
        if (wr & sel_dh) begin
          eeprom_divider_high_r <= avs_writedata[nvpe_pkg::DIVH_W-1:0];
        end
        if (wr & sel_dl) begin
          eeprom_divider_low_r <= avs_writedata[nvpe_pkg::DIVL_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eeprom_module_config_r <= nvpe_pkg::MCFG_RST;
    end else if (wr & sel_mc) begin
      eeprom_module_config_r <= avs_writedata[7:0];
    end
  end

  // Flash sequencer
  always_comb begin
    fstate_nxt = fstate_r;
    unique case (fstate_r)
      FS_IDLE: begin
        if (start_prog) begin
          fstate_nxt = FS_PROG;
        end else if (start_erase) begin
          fstate_nxt = FS_ERASE;
        end
      end
      FS_PROG, FS_ERASE: begin
        if (flash_done) begin
          fstate_nxt = FS_IDLE;
        end
      end
      default: fstate_nxt = FS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fstate_r <= FS_IDLE;
      fcnt_r <= 32'h00000000;
      row_r <= '0;
    end else begin
      fstate_r <= fstate_nxt;
      fcnt_r <= (flash_busy & ~flash_done) ? fcnt_r + 1'b1 : 32'h00000000;
      if (start_prog) begin
        row_r <= avs_writedata[nvpe_pkg::FC_ROW_LSB +: nvpe_pkg::FC_ROW_W];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_prog_active <= 1'b0;
      flash_erase_active <= 1'b0;
      flash_row <= '0;
      ee_hv_active <= 1'b0;
      ee_erase_mode <= 1'b0;
    end else begin
      flash_prog_active <= (fstate_nxt == FS_PROG);
      flash_erase_active <= (fstate_nxt == FS_ERASE);
      flash_row <= start_prog ? avs_writedata[nvpe_pkg::FC_ROW_LSB +: nvpe_pkg::FC_ROW_W] : row_r;
      ee_hv_active <= program_pulse_enable_r & ~ee_done & ~(wr_ep & ~avs_writedata[nvpe_pkg::EP_PULSE]);
      ee_erase_mode <= ee_erase_r;
    end
  end

  // EEPROM program control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      auto_r <= 1'b0;
      latch_r <= 1'b0;
      ee_erase_r <= 1'b0;
      program_pulse_enable_r <= 1'b0;
      ticks_r <= '0;
      ee_writes_r <= 4'h0;
    end else begin
      if (wr_ep) begin
        auto_r <= avs_writedata[nvpe_pkg::EP_AUTO];
        latch_r <= avs_writedata[nvpe_pkg::EP_LATCH];
        if (~program_pulse_enable_r) begin
          ee_erase_r <= avs_writedata[nvpe_pkg::EP_ERASE];
        end
      end
      if (ee_done) begin
        program_pulse_enable_r <= 1'b0;
      end else if (wr_ep) begin
        program_pulse_enable_r <= avs_writedata[nvpe_pkg::EP_PULSE];
      end
      if (~program_pulse_enable_r) begin
        ticks_r <= '0;
      end else if (tick) begin
        ticks_r <= ticks_r + 1'b1;
      end
      // Count program pulses since the last erase
      if (wr_ep & avs_writedata[nvpe_pkg::EP_PULSE] & ~program_pulse_enable_r) begin
        if (avs_writedata[nvpe_pkg::EP_ERASE]) begin
          ee_writes_r <= 4'h0;
        end else if (ee_writes_r != 4'hF) begin
          ee_writes_r <= ee_writes_r + 1'b1;
        end
      end
    end
  end
endmodule

// >>> testbench/nvpe_top_monitor.sv
/* Port checker for the program and erase controller.
   Bound to nvpe_top; sees only its ports. */
`timescale 1ns/10ps
module nvpe_top_monitor #(
  parameter int FLASH_ERASE_CYCLES = 50,
  parameter int FLASH_PROG_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic flash_prog_active,
  input wire logic flash_erase_active,
  input wire logic [nvpe_pkg::FC_ROW_W-1:0] flash_row,
  input wire logic ee_hv_active,
  input wire logic ee_erase_mode
);
  logic [31:0] pc_r;
  logic [31:0] ec_r;
  // Length of the current flash operation in cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_r <= 32'h0;
      ec_r <= 32'h0;
    end else begin
      pc_r <= flash_prog_active ? pc_r + 32'h1 : 32'h0;
      ec_r <= flash_erase_active ? ec_r + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req_rise;
    $rose(avs_read || avs_write);
  endsequence
  sequence s_one_wait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_wait_answer: assert property (s_req_rise |=> s_one_wait)
    else $error("answer not a single cycle");
  a_idle_wait: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_flash_excl: assert property (!(flash_prog_active && flash_erase_active))
    else $error("program and erase together");
  a_busy_erase: assert property (flash_prog_active |=> !$rose(flash_erase_active))
    else $error("erase started while busy");
  a_prog_time: assert property ($fell(flash_prog_active) |->
    pc_r >= FLASH_PROG_CYCLES && pc_r <= FLASH_PROG_CYCLES + 1)
    else $error("row program time wrong");
  a_erase_time: assert property ($fell(flash_erase_active) |->
    ec_r >= FLASH_ERASE_CYCLES && ec_r <= FLASH_ERASE_CYCLES + 1)
    else $error("bulk erase time wrong");
  a_row_hold: assert property (flash_prog_active && $past(flash_prog_active) |-> $stable(flash_row))
    else $error("row changed in program");
  a_mode_hold: assert property (ee_hv_active && $past(ee_hv_active) |-> $stable(ee_erase_mode))
    else $error("erase select changed in pulse");
endmodule
bind nvpe_top nvpe_top_monitor #(.FLASH_ERASE_CYCLES(FLASH_ERASE_CYCLES), .FLASH_PROG_CYCLES(FLASH_PROG_CYCLES)) u_mon (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .flash_prog_active(flash_prog_active), .flash_erase_active(flash_erase_active), .flash_row(flash_row),
  .ee_hv_active(ee_hv_active), .ee_erase_mode(ee_erase_mode));

// >>> testbench/tb_nvpe_top.sv
/* Bench for nvpe_top: Avalon-MM accesses with expected values.
   Assumes the monitor is bound to the design. */
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_nvpe_top;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, xtal, fpa, fea, hv, em;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, d, ep;
  logic [9:0] shadow;
  logic [10:0] row;
  logic [2:0] xc = 3'h0;
  int n_fail, compares, cyc, t0, i, m, tk;
  nvpe_top #(.FLASH_ERASE_CYCLES(50), .FLASH_PROG_CYCLES(20)) DUT (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .crystal_clock_input(xtal),
    .shadow_divider(shadow), .flash_prog_active(fpa), .flash_erase_active(fea), .flash_row(row),
    .ee_hv_active(hv), .ee_erase_mode(em));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Crystal clock with one rise every 8 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    xc <= xc + 3'h1;
    xtal <= xc[2];
  end
  task automatic finish_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= w;
    avs_read <= !w;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      finish_test();
    end
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    n_fail = 0;
    compares = 0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    shadow = 10'h2A5;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    acc(0, nvpe_pkg::ADDR_EE_DIVH, 0); `CHK(d, 32'h2)
    acc(0, nvpe_pkg::ADDR_EE_DIVL, 0); `CHK(d, 32'hA5)
    acc(1, 5'h18, 32'hFF);
    acc(0, 5'h18, 0); `CHK(d, 32'h0)
    acc(1, nvpe_pkg::ADDR_EE_DIVH, 0);
    acc(1, nvpe_pkg::ADDR_EE_DIVL, 32'h1);
    acc(0, nvpe_pkg::ADDR_EE_DIVL, 0); `CHK(d, 32'h1)
    // Two automatic programs then one automatic erase, tick every 16 cycles
    for (m = 0; m < 3; m++) begin
      ep = 32'h22 | (m == 2 ? 32'h4 : 32'h0);
      tk = (m == 2) ? 20 : 10;
      acc(1, nvpe_pkg::ADDR_EE_PROG, ep);
      acc(0, nvpe_pkg::ADDR_EE_PROG, 0); `CHK(d, ep)
      acc(1, nvpe_pkg::ADDR_EE_PROG, ep | 32'h1);
      t0 = cyc;
      @(negedge clk);
      `CHK({hv, em}, {1'b1, m == 2})
      d = 32'h1;
      for (i = 0; i < 200 && d[0] !== 1'b0; i++) acc(0, nvpe_pkg::ADDR_EE_PROG, 0);
      `CHK(i < 200 && cyc - t0 >= tk * 16 - 20 && cyc - t0 <= tk * 16 + 40, 1'b1)
      acc(0, nvpe_pkg::ADDR_STATUS, 0); `CHK(d[3:0], (m == 2) ? 4'h0 : 4'(m + 1))
    end
    // Without automatic timing the pulse stays on
    acc(1, nvpe_pkg::ADDR_EE_PROG, 32'h3);
    repeat (400) @(posedge clk);
    acc(0, nvpe_pkg::ADDR_EE_PROG, 0); `CHK(d[0], 1'b1)
    acc(1, nvpe_pkg::ADDR_EE_PROG, 32'h0);
    // Program and erase written together: row program wins
    acc(1, nvpe_pkg::ADDR_FLASH_CTRL, 32'h503);
    t0 = cyc;
    `CHK({fpa, fea, row}, {2'b10, 11'h5})
    acc(1, nvpe_pkg::ADDR_FLASH_CTRL, 32'h2); `CHK(fea, 1'b0)
    d = 32'h4;
    for (i = 0; i < 40 && d[2] !== 1'b0; i++) acc(0, nvpe_pkg::ADDR_FLASH_CTRL, 0);
    `CHK(i < 40 && cyc - t0 >= 15 && cyc - t0 <= 30, 1'b1)
    acc(1, nvpe_pkg::ADDR_FLASH_CTRL, 32'h2);
    t0 = cyc;
    `CHK({fpa, fea}, 2'b01)
    d = 32'h4;
    for (i = 0; i < 60 && d[2] !== 1'b0; i++) acc(0, nvpe_pkg::ADDR_FLASH_CTRL, 0);
    `CHK(i < 60 && cyc - t0 >= 45 && cyc - t0 <= 60, 1'b1)
    // Reset in mid-run reloads both divider registers from the shadow word
    shadow <= 10'h15A;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    acc(0, nvpe_pkg::ADDR_EE_DIVH, 0); `CHK(d, 32'h1)
    acc(0, nvpe_pkg::ADDR_EE_DIVL, 0); `CHK(d, 32'h5A)
    finish_test();
  end
endmodule
